//--- inc/pcbx_pkg.sv
/*
 * Shared constants and state type of the priority crossbar pin router.
 * Assumes three 8-pin ports, routed as one 24-pin vector with port n at bits 8n+7..8n.
 */
package pcbx_pkg;

    localparam int NPORT = 3;
    localparam int PW    = 8;
    localparam int NPIN  = NPORT * PW;
    localparam int NFUNC = 15;
    localparam int FW    = 4;

    // Routable functions, listed from highest to lowest priority
    localparam logic [FW-1:0] F_SDA  = 4'h0;
    localparam logic [FW-1:0] F_SCL  = 4'h1;
    localparam logic [FW-1:0] F_TX   = 4'h2;
    localparam logic [FW-1:0] F_RX   = 4'h3;
    localparam logic [FW-1:0] F_SCK  = 4'h4;
    localparam logic [FW-1:0] F_MISO = 4'h5;
    localparam logic [FW-1:0] F_MOSI = 4'h6;
    localparam logic [FW-1:0] F_NSS  = 4'h7;
    localparam logic [FW-1:0] F_CLK  = 4'h8;
    localparam logic [FW-1:0] F_CAPCOMP_CHAN_A = 4'h9;
    localparam logic [FW-1:0] F_CEX1 = 4'ha;
    localparam logic [FW-1:0] F_CEX2 = 4'hb;
    localparam logic [FW-1:0] F_ECI  = 4'hc;
    localparam logic [FW-1:0] F_T0   = 4'hd;
    localparam logic [FW-1:0] F_T1   = 4'he;
    localparam logic [FW-1:0] F_GPIO = 4'hf;

    // Field positions in route_select_low
    localparam int RSL_UART    = 0;
    localparam int RSL_SPI     = 1;
    localparam int RSL_SMB     = 2;
    localparam int RSL_CLK     = 3;
    localparam int RSL_CAP_LSB = 4;
    localparam int RSL_ECI     = 7;

    // Field positions in route_select_high
    localparam int RSH_T0 = 0;
    localparam int RSH_T1 = 1;

    // Capture-compare routing field codes
    localparam logic [2:0] CAP_NONE  = 3'h0;
    localparam logic [2:0] CAP_ONE   = 3'h1;
    localparam logic [2:0] CAP_TWO   = 3'h2;
    localparam logic [2:0] CAP_THREE = 3'h3;

    // Select-mode code for three-wire SPI
    localparam logic [1:0] SPI_THREE_WIRE = 2'h0;

    localparam logic [NPIN*FW-1:0] RST_ROUTE     = {NPIN{F_GPIO}};
    localparam logic [NPIN-1:0]    RST_PULLUP    = 24'hffffff;
    localparam logic [NPIN-1:0]    RST_DRIVE     = 24'h000000;
    localparam logic [NFUNC-1:0]   RST_PERIPH_IN = 15'h7fff;
    // Pads idle high under pull-up; a low reset level would fake an edge at release
    localparam logic [NPIN-1:0]    RST_LEVEL     = 24'hffffff;

    typedef struct packed {
        logic [NPIN-1:0][FW-1:0] route;
        logic [NPIN-1:0]         pin_out;
        logic [NPIN-1:0]         pin_oe;
        logic [NPIN-1:0]         pin_pullup;
        logic [NPIN-1:0]         fixed_level;
        logic [NPIN-1:0]         fixed_edge;
        logic [NFUNC-1:0]        periph_in;
        logic [NPORT-1:0]        port_mismatch;
        logic                    mismatch;
    } pcbx_state_t;

    localparam pcbx_state_t ST_RESET = '{
        route:         RST_ROUTE,
        pin_out:       RST_DRIVE,
        pin_oe:        RST_DRIVE,
        pin_pullup:    RST_PULLUP,
        fixed_level:   RST_LEVEL,
        fixed_edge:    RST_DRIVE,
        periph_in:     RST_PERIPH_IN,
        port_mismatch: 3'h0,
        mismatch:      1'b0
    };

endpackage : pcbx_pkg

//--- logic/pcbx_port_match.sv
/*
 * One port's pattern comparator, purely combinational.
 * Assumes the caller registers the result and feeds pins already read as digital.
 */
`timescale 1ns/1ps
module pcbx_port_match #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pins,
    input  wire logic [W-1:0] mask,
    input  wire logic [W-1:0] expected,
    output logic              mismatch
);

    // Masked levels against masked expectation
    assign mismatch = (pins & mask) != (expected & mask);

endmodule : pcbx_port_match

//--- logic/pcbx_router.sv
/*
 * Priority crossbar: hands enabled peripheral signals the lowest free pins,
 * drives the pin cells, returns pin levels to peripherals, and watches
 * fixed-function edges and port patterns.
 * Assumes all inputs synchronous to clk; pin wire level is resolved outside.
 */
`timescale 1ns/1ps
module pcbx_router
    import pcbx_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [7:0]           route_select_low,
    input  wire logic [1:0]           route_select_high,
    input  wire logic                 router_on,
    input  wire logic                 weak_pull_off,
    input  wire logic                 spi_select_mode_hi,
    input  wire logic                 spi_select_mode_lo,
    input  wire logic [NPIN-1:0]      pin_skip_mask,
    input  wire logic [NPIN-1:0]      pin_input_kind_select,
    input  wire logic [NPIN-1:0]      pin_push_pull,
    input  wire logic [NPIN-1:0]      pin_compare_mask,
    input  wire logic [NPIN-1:0]      pin_expected_value,
    input  wire logic [NPIN-1:0]      port_latch,
    input  wire logic [NFUNC-1:0]     periph_out,
    input  wire logic [NFUNC-1:0]     periph_oe,
    input  wire logic [NPIN-1:0]      pin_in,
    output logic      [NPIN-1:0]      pin_out,
    output logic      [NPIN-1:0]      pin_oe,
    output logic      [NPIN-1:0]      pin_pullup,
    output logic      [NPIN*FW-1:0]   pin_route,
    output logic      [NFUNC-1:0]     periph_in,
    output logic      [NPIN-1:0]      fixed_level,
    output logic      [NPIN-1:0]      fixed_edge,
    output logic                      port_mismatch
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port match, one comparator per port

    logic [NPIN-1:0]  digital_level;
    logic [NPORT-1:0] port_mm;

    // Analog pins read as zero
    assign digital_level = pin_in & pin_input_kind_select;

    for (genvar g = 0; g < NPORT; g++) begin : g_match
        pcbx_port_match #(
            .W (PW)
        ) u_match (
            .pins     (digital_level[g*PW +: PW]),
            .mask     (pin_compare_mask[g*PW +: PW]),
            .expected (pin_expected_value[g*PW +: PW]),
            .mismatch (port_mm[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enabled functions in priority order

    logic [NFUNC-1:0] func_en;
    logic [2:0]       cap_sel;
    logic             four_wire;

    assign cap_sel   = route_select_low[RSL_CAP_LSB +: 3];
    assign four_wire = {spi_select_mode_hi, spi_select_mode_lo} != SPI_THREE_WIRE;

    always_comb begin
        func_en         = '0;
        func_en[F_SDA]  = route_select_low[RSL_SMB];
        func_en[F_SCL]  = route_select_low[RSL_SMB];
        func_en[F_TX]   = route_select_low[RSL_UART];
        func_en[F_RX]   = route_select_low[RSL_UART];
        func_en[F_SCK]  = route_select_low[RSL_SPI];
        func_en[F_MISO] = route_select_low[RSL_SPI];
        func_en[F_MOSI] = route_select_low[RSL_SPI];
        func_en[F_NSS]  = route_select_low[RSL_SPI] && four_wire;
        func_en[F_CLK]  = route_select_low[RSL_CLK];
        // Codes above three are reserved and route nothing
        func_en[F_CAPCOMP_CHAN_A] = cap_sel == CAP_ONE || cap_sel == CAP_TWO
                          || cap_sel == CAP_THREE;
        func_en[F_CEX1] = cap_sel == CAP_TWO || cap_sel == CAP_THREE;
        func_en[F_CEX2] = cap_sel == CAP_THREE;
        func_en[F_ECI]  = route_select_low[RSL_ECI];
        func_en[F_T0]   = route_select_high[RSH_T0];
        func_en[F_T1]   = route_select_high[RSH_T1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    pcbx_state_t st;
    pcbx_state_t next_st;

    always_comb begin
        logic [NPIN-1:0] taken;
        logic            found;
        logic [FW-1:0]   fsel;
        logic            val;
        logic            drv;
        logic            dig;
        logic            low_on;
        logic            high_on;
        taken   = pin_skip_mask;
        found   = 1'b0;
        fsel    = F_GPIO;
        val     = 1'b1;
        drv     = 1'b0;
        dig     = 1'b0;
        low_on  = 1'b0;
        high_on = 1'b0;
        next_st = st;
        next_st.route = RST_ROUTE;
        // Whole map rebuilt every cycle, so a config change lands next edge
        if (router_on) begin
            for (int f = 0; f < NFUNC; f++) begin
                found = 1'b0;
                if (func_en[f]) begin
                    for (int p = 0; p < NPIN; p++) begin
                        if (!found && !taken[p]) begin
                            next_st.route[p] = f[FW-1:0];
                            taken[p]         = 1'b1;
                            found            = 1'b1;
                        end
                    end
                end
            end
        end
        next_st.periph_in = RST_PERIPH_IN;
        for (int p = 0; p < NPIN; p++) begin
            fsel = next_st.route[p];
            dig  = pin_input_kind_select[p];
            if (fsel != F_GPIO) begin
                val = periph_out[fsel];
                drv = periph_oe[fsel];
                next_st.periph_in[fsel] = pin_in[p] & dig;
            end else begin
                val = port_latch[p];
                drv = 1'b1;
            end
            // Open-drain unless push-pull; no driver ever on an analog pin
            low_on  = router_on && dig && drv && !val;
            high_on = router_on && dig && drv && val && pin_push_pull[p];
            next_st.pin_out[p]    = val;
            next_st.pin_oe[p]     = low_on || high_on;
            // Pull-up off while sinking, saves static current
            next_st.pin_pullup[p] = dig && !low_on && !weak_pull_off;
        end
        next_st.fixed_level   = digital_level;
        next_st.fixed_edge    = digital_level ^ st.fixed_level;
        next_st.port_mismatch = port_mm;
        next_st.mismatch      = |port_mm;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pin_out       = st.pin_out;
    assign pin_oe        = st.pin_oe;
    assign pin_pullup    = st.pin_pullup;
    assign pin_route     = st.route;
    assign periph_in     = st.periph_in;
    assign fixed_level   = st.fixed_level;
    assign fixed_edge    = st.fixed_edge;
    assign port_mismatch = st.mismatch;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    function automatic int route_count(input logic [NPIN-1:0][FW-1:0] r,
                                       input logic [FW-1:0] f);
        int n;
        n = 0;
        for (int p = 0; p < NPIN; p++) begin
            if (r[p] == f) begin
                n++;
            end
        end
        return n;
    endfunction : route_count

    function automatic int lowest_free(input logic [NPIN-1:0] m);
        int idx;
        idx = 0;
        for (int p = NPIN - 1; p >= 0; p--) begin
            if (!m[p]) begin
                idx = p;
            end
        end
        return idx;
    endfunction : lowest_free

    chk_off_no_drive: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !router_on |=> pin_oe == '0)
        else $error("pin driven while crossbar off");

    chk_smb_first: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (router_on && route_select_low[RSL_SMB] && !(&pin_skip_mask))
        |=> st.route[lowest_free($past(pin_skip_mask))] == F_SDA)
        else $error("SDA not on lowest free pin");

    chk_uart_pair: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (router_on && route_select_low[RSL_UART] && $countones(~pin_skip_mask) >= NFUNC)
        |=> route_count(st.route, F_TX) == 1 && route_count(st.route, F_RX) == 1)
        else $error("UART pair not routed");

    chk_smb_pair: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (router_on && route_select_low[RSL_SMB] && $countones(~pin_skip_mask) >= 2)
        |=> route_count(st.route, F_SCL) == 1)
        else $error("SCL not routed with SDA");

    chk_nss_three: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (route_select_low[RSL_SPI] && !four_wire) |=> route_count(st.route, F_NSS) == 0)
        else $error("NSS routed in three-wire mode");

    chk_skip_free: assert property (@(posedge clk) disable iff (!rst_sync_n)
        1'b1 |=> (route_count(st.route, F_GPIO) >= $countones($past(pin_skip_mask))))
        else $error("skipped pin given a function");

    chk_cap_none: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (cap_sel == CAP_NONE) |=> route_count(st.route, F_CAPCOMP_CHAN_A) == 0
            && route_count(st.route, F_CEX1) == 0 && route_count(st.route, F_CEX2) == 0)
        else $error("capture channel routed with field zero");

    chk_analog_quiet: assert property (@(posedge clk) disable iff (!rst_sync_n)
        1'b1 |=> (fixed_level & ~$past(pin_input_kind_select)) == '0)
        else $error("fixed level seen on analog pin");

    chk_edge_pulse: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $past(rst_sync_n) |-> fixed_edge == (fixed_level ^ $past(fixed_level)))
        else $error("fixed edge pulse disagrees with level change");

    chk_mismatch_eq: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ((digital_level & pin_compare_mask) != (pin_expected_value & pin_compare_mask))
        |=> port_mismatch)
        else $error("mismatch not raised");

    chk_match_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ((digital_level & pin_compare_mask) == (pin_expected_value & pin_compare_mask))
        |=> !port_mismatch)
        else $error("mismatch raised on matching pins");

    chk_off_route: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !router_on |=> pin_route == RST_ROUTE)
        else $error("function routed while crossbar off");

    chk_analog_pull: assert property (@(posedge clk) disable iff (!rst_sync_n)
        1'b1 |=> (pin_pullup & ~$past(pin_input_kind_select)) == '0)
        else $error("pull-up on analog pin");

    // Per-pin view; the count check above cannot see a swapped pin
    function automatic logic skip_taken(input logic [NPIN-1:0][FW-1:0] r,
                                        input logic [NPIN-1:0] m);
        logic hit;
        hit = 1'b0;
        for (int p = 0; p < NPIN; p++) begin
            if (m[p] && r[p] != F_GPIO) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : skip_taken

    chk_skip_kept: assert property (@(posedge clk) disable iff (!rst_sync_n)
        1'b1 |=> !skip_taken(st.route, $past(pin_skip_mask)))
        else $error("skipped pin carries a function");

endmodule : pcbx_router

//--- tb/pcbx_board.sv
/*
 * Board model on the far side of the pins: resolves each pad level.
 * Assumes the bench chooses which pads an outside source drives.
 */
`timescale 1ns/1ps
module pcbx_board
    import pcbx_pkg::*;
(
    input  wire logic            clk,
    input  wire logic [NPIN-1:0] pin_out,
    input  wire logic [NPIN-1:0] pin_oe,
    input  wire logic [NPIN-1:0] pin_pullup,
    input  wire logic [NPIN-1:0] ext_en,
    input  wire logic [NPIN-1:0] ext_val,
    output logic      [NPIN-1:0] pin_in
);
    // Floating pads wander so a stale value never passes
    logic [NPIN-1:0] wobble = 24'h5a5a5a;
    always_ff @(posedge clk) begin
        wobble <= ~wobble;
    end
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            pin_in[p] = pin_oe[p] ? pin_out[p] : ext_en[p] ? ext_val[p] :
                        pin_pullup[p] ? 1'b1 : wobble[p];
        end
    end
endmodule : pcbx_board

//--- tb/testbench.sv
/*
 * Directed bench for the crossbar router: route tables, pin drive, fixed edges.
 * Assumes the design reacts on the edge after inputs land, board model on pins.
 */
`timescale 1ns/1ps
module testbench
    import pcbx_pkg::*;
;
    logic clk, rst_n, on, wpo, ssh, ssl;
    logic [7:0] rsl;
    logic [1:0] rsh;
    logic [NPIN-1:0] skip, kind, pp, cmask, cexp, latch, ext_en, ext_val, pin_in;
    logic [NPIN-1:0] pin_out, pin_oe, pin_pullup, fixed_level, fixed_edge;
    logic [NFUNC-1:0] pout, poe, periph_in;
    logic [NPIN*FW-1:0] pin_route;
    logic match_flag;
    int err_total = 0;
    int n_compared = 0;

    pcbx_router i_dut (.clk(clk), .rst_n(rst_n), .route_select_low(rsl),
        .route_select_high(rsh), .router_on(on), .weak_pull_off(wpo),
        .spi_select_mode_hi(ssh), .spi_select_mode_lo(ssl), .pin_skip_mask(skip),
        .pin_input_kind_select(kind), .pin_push_pull(pp), .pin_compare_mask(cmask),
        .pin_expected_value(cexp), .port_latch(latch), .periph_out(pout),
        .periph_oe(poe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_route(pin_route), .periph_in(periph_in),
        .fixed_level(fixed_level), .fixed_edge(fixed_edge), .port_mismatch(match_flag));
    pcbx_board i_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [95:0] e, input logic [95:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Independent routing model: walk functions in code order, lowest free pin
    function automatic logic [95:0] exp_route(input logic [7:0] s, input logic [1:0] h,
                                              input logic nss4, input logic [23:0] sk);
        logic [14:0] en;
        logic [95:0] r;
        logic [2:0]  c;
        int          p;
        c = s[6:4];
        r = {NPIN{F_GPIO}};
        en = {h[1], h[0], s[7], c == 3'h3, c == 3'h2 || c == 3'h3, c != 3'h0 && c < 3'h4,
              s[3], s[1] & nss4, {3{s[1]}}, {2{s[0]}}, {2{s[2]}}};
        p = 0;
        for (int f = 0; f < NFUNC; f++) begin
            if (en[f]) begin
                while (p < NPIN && sk[p]) p++;
                if (p < NPIN) r[4*p +: 4] = 4'(f);
                p++;
            end
        end
        return r;
    endfunction : exp_route

    task automatic rt(input logic [7:0] s, input logic [1:0] h, input logic [1:0] m,
                      input logic [23:0] sk, input logic o);
        @(posedge clk);
        rsl <= s;
        rsh <= h;
        {ssh, ssl} <= m;
        skip <= sk;
        on <= o;
        settle();
        chk("pin_route", o ? exp_route(s, h, m != 2'h0, sk) : RST_ROUTE, pin_route);
        if (!o) chk("pin_oe off", 96'(RST_DRIVE), 96'(pin_oe));
    endtask : rt

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        on = 1'b0;
        wpo = 1'b0;
        ssh = 1'b0;
        ssl = 1'b0;
        rsl = 8'h00;
        rsh = 2'h0;
        skip = 24'h000000;
        kind = 24'hffffff;
        pp = 24'h000000;
        cmask = 24'h000000;
        cexp = 24'h000000;
        latch = 24'hffffff;
        ext_en = 24'h000000;
        ext_val = 24'h000000;
        pout = 15'h7fff;
        poe = 15'h0000;
        @(posedge clk);
        #1;
        chk("reset pin_oe", 96'(RST_DRIVE), 96'(pin_oe));
        chk("reset pullup", 96'(RST_PULLUP), 96'(pin_pullup));
        chk("reset route", RST_ROUTE, pin_route);
        chk("reset periph_in", 96'(RST_PERIPH_IN), 96'(periph_in));
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // First update after release must not show edges on idle pads
        chk("reset edge", 96'(RST_DRIVE), 96'(fixed_edge));
        $display("test reset done");

        rt(8'h26, 2'h0, 2'h1, 24'h000318, 1'b1);
        rt(8'hbf, 2'h3, 2'h0, 24'h000000, 1'b1);
        rt(8'hbf, 2'h3, 2'h2, 24'h1000c1, 1'b1);
        rt(8'h05, 2'h0, 2'h0, 24'hfffffe, 1'b1);
        rt(8'hbf, 2'h3, 2'h3, 24'h000000, 1'b0);
        for (int c = 0; c < 8; c++) rt({1'b0, 3'(c), 4'h0}, 2'h0, 2'h0, 24'h0, 1'b1);
        $display("test routing done");

        // SMBus on pins 0/1, plain I/O on pins 2 and 3
        @(posedge clk);
        poe[F_SDA] <= 1'b1;
        pout[F_SDA] <= 1'b0;
        latch <= 24'hfffffb;
        pp <= 24'h000008;
        ext_en <= 24'h000002;
        rt(8'h04, 2'h0, 2'h0, 24'h000000, 1'b1);
        chk("pin_oe low pins", 96'h0d, 96'(pin_oe[3:0]));
        chk("pin_out low pins", 96'h08, 96'(pin_out[3:0] & 4'hd));
        chk("periph_in scl", 96'h0, 96'(periph_in[F_SCL]));
        $display("test drive done");

        // Fixed functions with crossbar off: pin 4 digital, pin 5 analog
        rt(8'h00, 2'h0, 2'h0, 24'h000020, 1'b0);
        @(posedge clk);
        kind <= 24'hffffdf;
        ext_en <= 24'h000000;
        settle();
        chk("analog pullup", 96'h0, 96'(pin_pullup[5]));
        @(posedge clk);
        ext_en <= 24'h000010;
        @(posedge clk);
        #1;
        chk("level pin4", 96'h0, 96'(fixed_level[4]));
        chk("edge pin4", 96'h1, 96'(fixed_edge[4]));
        chk("level analog", 96'h0, 96'(fixed_level[5]));
        @(posedge clk);
        #1;
        chk("edge pin4 end", 96'h0, 96'(fixed_edge[4]));
        $display("test fixed done");

        // Port 2 pin 0 pulled high, analog pin 5 compares as low
        @(posedge clk);
        cmask <= 24'h010020;
        settle();
        chk("mismatch", 96'h1, 96'(match_flag));
        @(posedge clk);
        cexp <= 24'h010000;
        settle();
        chk("match", 96'h0, 96'(match_flag));
        @(posedge clk);
        wpo <= 1'b1;
        settle();
        chk("pullups off", 96'h0, 96'(pin_pullup));
        $display("test match done");
        wrap_up();
    end

    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule : testbench
